// >>> src/uie_top.sv
// uie_top: one channel's register port, interrupt enables, status and
// enhanced flow-control characters. assumes the receive and transmit
// datapaths report levels and errors, and take the hold/reset pulses.
`timescale 1ns/1ps

// Operation
// - receive data interrupt: holding char in plain mode, trigger reached in fifo mode
// - fifo mode: receive status and interrupt drop once level falls below trigger
// - data ready set when a char enters the fifo, cleared only when empty
// - line status bit 1 overrun, bits 2-4 errors of the head byte
// - bit 5 transmit holding empty, bit 6 holding and shift both empty
// - bit 7 set while any fifo character carries an error
// - transmit ready: holding empty, or fifo below transmit trigger
// - enabling transmit ready while already empty interrupts at once
// - line status interrupt from bits 1 to 4 when enabled
// - enable bit 3 gates the modem status interrupt
// - enable bit 4 selects sleep, writable only under enhanced access
// - enable bit 5 gates stop character interrupt, enhanced access only
// - enable bit 6 interrupts on request-to-send rise under auto control
// - every enable bit is zero after reset
// - enhanced feature fields: auto cts, auto rts, special, access, soft flow
// - offsets 4 to 7 hold resume and stop characters under the key
// - status bit 0 low while pending, high when idle and after reset
// - enable bit 7 interrupts on clear-to-send rise under auto control
module uie_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register port
  input wire uie_pkg::uie_bus_s bus,
  output logic [7:0] rdata_ff,
  // datapath status
  input wire uie_pkg::uie_rx_s rx_stat,
  input wire uie_pkg::uie_tx_s tx_stat,
  input wire logic [7:0] rx_hold_data,
  input wire logic [7:0] modem_stat,
  input wire logic modem_delta,
  input wire logic stop_char_seen,
  input wire logic resume_char_seen,
  input wire logic rts_out_high,
  input wire logic cts_in_high,
  // datapath strobes
  output logic rx_hold_rd_ff,
  output logic tx_hold_wr_ff,
  output logic [7:0] tx_hold_data_ff,
  output logic modem_stat_rd_ff,
  output logic rx_fifo_rst_ff,
  output logic tx_fifo_rst_ff,
  // configuration out
  output logic [7:0] line_control_reg_ff,
  output logic [7:0] enhanced_feature_ctrl_ff,
  output logic [7:0] resume_char_one_ff,
  output logic [7:0] resume_char_two_ff,
  output logic [7:0] stop_char_one_ff,
  output logic [7:0] stop_char_two_ff,
  output logic [7:0] modem_control_reg_ff,
  output logic fifo_en_ff,
  output logic sleep_en_ff,
  // interrupt
  output logic irq_ff
);
  logic [7:0] interrupt_enable_mask_ff;
  logic [7:0] fifo_control_reg_ff;
  logic [7:0] scratch_ff;
  logic overrun_ff;
  logic tx_int_ff;
  logic tx_cond_ff;
  logic tx_en_prev_ff;
  logic stop_int_ff;
  logic flow_int_ff;
  logic [1:0] flow_rise;

  // address decode
  wire enh_map = line_control_reg_ff == uie_pkg::LCTRL_KEY;
  wire div_map = line_control_reg_ff[uie_pkg::LCTRL_DIV_BIT];
  wire norm_map = ~div_map;
  wire rd_acc = bus.cs & bus.rd;
  wire wr_acc = bus.cs & bus.wr;
  wire hit_hold = norm_map & (bus.addr == uie_pkg::OFS_HOLD);
  wire hit_ien = norm_map & (bus.addr == uie_pkg::OFS_IEN);
  wire hit_istat = norm_map & (bus.addr == uie_pkg::OFS_ISTAT);
  wire hit_lctrl = bus.addr == uie_pkg::OFS_LCTRL;
  wire hit_mctrl = norm_map & (bus.addr == uie_pkg::OFS_MCTRL);
  wire hit_lstat = norm_map & (bus.addr == uie_pkg::OFS_LSTAT);
  wire hit_mstat = norm_map & (bus.addr == uie_pkg::OFS_MSTAT);
  wire hit_scr = norm_map & (bus.addr == uie_pkg::OFS_SCRATCH);
  wire hit_efc = enh_map & (bus.addr == uie_pkg::OFS_EFC);
  wire hit_res1 = enh_map & (bus.addr == uie_pkg::OFS_RES1);
  wire hit_res2 = enh_map & (bus.addr == uie_pkg::OFS_RES2);
  wire hit_stop1 = enh_map & (bus.addr == uie_pkg::OFS_STOP1);
  wire hit_stop2 = enh_map & (bus.addr == uie_pkg::OFS_STOP2);

  // enhanced access gate and effective enables
  wire enh_on = enhanced_feature_ctrl_ff[uie_pkg::EFC_ENH];
  wire [7:0] ien_eff = {interrupt_enable_mask_ff[7:4] & {4{enh_on}},
    interrupt_enable_mask_ff[3:0]};
  wire auto_rts = enhanced_feature_ctrl_ff[uie_pkg::EFC_AUTO_RTS];
  wire auto_cts = enhanced_feature_ctrl_ff[uie_pkg::EFC_AUTO_CTS];

  // trigger levels
  wire [5:0] rx_trig = uie_pkg::RX_TRIG_TBL[fifo_control_reg_ff[7:6]];
  wire [5:0] tx_trig = uie_pkg::TX_TRIG_TBL[fifo_control_reg_ff[5:4]];

  // receive side conditions
  wire rx_ready = rx_stat.count != 6'h00;
  wire rx_level_hit = fifo_en_ff ? (rx_stat.count >= rx_trig) : rx_ready;
  wire head_err = rx_stat.brk | rx_stat.framing | rx_stat.parity;

  // transmit side conditions
  wire tx_empty = tx_stat.count == 6'h00;
  wire tx_cond = fifo_en_ff ? ((tx_stat.count < tx_trig) | tx_empty) : tx_empty;

  // line status value
  wire [7:0] lstat = {rx_stat.any_err,
    tx_empty & tx_stat.shift_empty, tx_empty,
    rx_stat.brk, rx_stat.framing, rx_stat.parity, overrun_ff,
    rx_ready};

  // pending sources, enabled
  wire pend_line = ien_eff[uie_pkg::IEN_LINE] & (overrun_ff | head_err);
  wire pend_rxto = ien_eff[uie_pkg::IEN_RX] & fifo_en_ff & rx_stat.timeout & rx_ready;
  wire pend_rx = ien_eff[uie_pkg::IEN_RX] & rx_level_hit;
  wire pend_tx = ien_eff[uie_pkg::IEN_TX] & tx_int_ff;
  wire pend_modem = ien_eff[uie_pkg::IEN_MODEM] & modem_delta;
  wire pend_stop = ien_eff[uie_pkg::IEN_STOPCH] & stop_int_ff;
  wire pend_flow = flow_int_ff;
  wire pend_any = pend_line | pend_rxto | pend_rx | pend_tx | pend_modem
    | pend_stop | pend_flow;

  // interrupt status by priority
  wire [5:0] isr_code =
    pend_line ? uie_pkg::ISC_LINE :
    pend_rxto ? uie_pkg::ISC_RXTO :
    pend_rx ? uie_pkg::ISC_RXRDY :
    pend_tx ? uie_pkg::ISC_TXRDY :
    pend_modem ? uie_pkg::ISC_MODEM :
    pend_stop ? uie_pkg::ISC_STOPCH :
    pend_flow ? uie_pkg::ISC_FLOW : uie_pkg::ISC_NONE;
  wire [7:0] isr_val = {fifo_en_ff, fifo_en_ff, isr_code};

  // read strobes with side effects
  wire rd_istat = rd_acc & hit_istat;
  wire rd_lstat = rd_acc & hit_lstat;
  wire rd_mstat = rd_acc & hit_mstat;
  wire rd_hold = rd_acc & hit_hold;
  // write strobes
  wire wr_hold = wr_acc & hit_hold;
  wire wr_ien = wr_acc & hit_ien;
  wire wr_fctl = wr_acc & hit_istat;
  wire wr_fctl_en = wr_fctl & bus.wdata[uie_pkg::FCTL_EN];

  // read data mux
  wire [7:0] rd_mux =
    hit_efc ? enhanced_feature_ctrl_ff :
    hit_res1 ? resume_char_one_ff :
    hit_res2 ? resume_char_two_ff :
    hit_stop1 ? stop_char_one_ff :
    hit_stop2 ? stop_char_two_ff :
    hit_lctrl ? line_control_reg_ff :
    hit_hold ? rx_hold_data :
    hit_ien ? ien_eff :
    hit_istat ? isr_val :
    hit_mctrl ? modem_control_reg_ff :
    hit_lstat ? lstat :
    hit_mstat ? modem_stat :
    hit_scr ? scratch_ff : uie_pkg::RST_BYTE;

  // next values
  wire [7:0] nxt_ien = {enh_on ? bus.wdata[7:4] : interrupt_enable_mask_ff[7:4],
    bus.wdata[3:0]};
  wire [7:0] nxt_fctl = {bus.wdata[7:6],
    enh_on ? bus.wdata[5:4] : fifo_control_reg_ff[5:4], bus.wdata[3:0]};
  // modem control high bits need enhanced access
  wire [7:0] nxt_mctrl = {enh_on ? bus.wdata[7:5] : modem_control_reg_ff[7:5],
    bus.wdata[4:0]};
  wire tx_en_now = ien_eff[uie_pkg::IEN_TX];
  // edge of the condition, or enable rising while it already holds
  wire tx_set = (tx_cond & ~tx_cond_ff) | (tx_en_now & ~tx_en_prev_ff & tx_cond);
  wire tx_clr = rd_istat | wr_hold;
  wire nxt_tx_int = tx_set | (tx_int_ff & ~tx_clr);
  wire nxt_overrun = rx_stat.overrun | (overrun_ff & ~rd_lstat);
  wire nxt_stop_int = stop_char_seen | (stop_int_ff & ~(rd_istat | resume_char_seen));
  wire flow_set = (ien_eff[uie_pkg::IEN_RTS] & auto_rts & flow_rise[0])
    | (ien_eff[uie_pkg::IEN_CTS] & auto_cts & flow_rise[1]);
  wire nxt_flow_int = flow_set | (flow_int_ff & ~rd_mstat);

  uie_rise_det #(
    .WIDTH(2)
  ) u_rise (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .level({cts_in_high, rts_out_high}),
    .rise(flow_rise)
  );

  // enables and feature registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      interrupt_enable_mask_ff <= uie_pkg::RST_BYTE;
      enhanced_feature_ctrl_ff <= uie_pkg::RST_BYTE;
      line_control_reg_ff <= uie_pkg::RST_BYTE;
      fifo_control_reg_ff <= uie_pkg::RST_BYTE;
      modem_control_reg_ff <= uie_pkg::RST_BYTE;
      scratch_ff <= uie_pkg::RST_BYTE;
    end else begin
      if (wr_ien) begin
        interrupt_enable_mask_ff <= nxt_ien;
      end
      if (wr_acc & hit_efc) begin
        enhanced_feature_ctrl_ff <= bus.wdata;
      end
      if (wr_acc & hit_lctrl) begin
        line_control_reg_ff <= bus.wdata;
      end
      if (wr_fctl_en) begin
        fifo_control_reg_ff <= nxt_fctl;
      end
      if (wr_acc & hit_mctrl) begin
        modem_control_reg_ff <= nxt_mctrl;
      end
      if (wr_acc & hit_scr) begin
        scratch_ff <= bus.wdata;
      end
    end
  end

  // flow-control characters
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      resume_char_one_ff <= uie_pkg::RST_BYTE;
      resume_char_two_ff <= uie_pkg::RST_BYTE;
      stop_char_one_ff <= uie_pkg::RST_BYTE;
      stop_char_two_ff <= uie_pkg::RST_BYTE;
    end else begin
      if (wr_acc & hit_res1) begin
        resume_char_one_ff <= bus.wdata;
      end
      if (wr_acc & hit_res2) begin
        resume_char_two_ff <= bus.wdata;
      end
      if (wr_acc & hit_stop1) begin
        stop_char_one_ff <= bus.wdata;
      end
      if (wr_acc & hit_stop2) begin
        stop_char_two_ff <= bus.wdata;
      end
    end
  end

  // fifo enable follows any fifo control write
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fifo_en_ff <= 1'b0;
      rx_fifo_rst_ff <= 1'b0;
      tx_fifo_rst_ff <= 1'b0;
    end else begin
      if (wr_fctl) fifo_en_ff <= bus.wdata[uie_pkg::FCTL_EN];
      rx_fifo_rst_ff <= wr_fctl_en & bus.wdata[uie_pkg::FCTL_RXRST];
      tx_fifo_rst_ff <= wr_fctl_en & bus.wdata[uie_pkg::FCTL_TXRST];
    end
  end

  // sticky sources; a set beats a same-cycle clear
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      overrun_ff <= 1'b0;
      tx_int_ff <= 1'b0;
      tx_cond_ff <= 1'b1;
      tx_en_prev_ff <= 1'b0;
      stop_int_ff <= 1'b0;
      flow_int_ff <= 1'b0;
    end else begin
      overrun_ff <= nxt_overrun;
      tx_int_ff <= nxt_tx_int;
      tx_cond_ff <= tx_cond;
      tx_en_prev_ff <= tx_en_now;
      stop_int_ff <= nxt_stop_int;
      flow_int_ff <= nxt_flow_int;
    end
  end

  // bus answer, datapath strobes, request line
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdata_ff <= uie_pkg::RST_BYTE;
      rx_hold_rd_ff <= 1'b0;
      tx_hold_wr_ff <= 1'b0;
      tx_hold_data_ff <= uie_pkg::RST_BYTE;
      modem_stat_rd_ff <= 1'b0;
      sleep_en_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      if (rd_acc) rdata_ff <= rd_mux;
      rx_hold_rd_ff <= rd_hold;
      tx_hold_wr_ff <= wr_hold;
      if (wr_hold) tx_hold_data_ff <= bus.wdata;
      modem_stat_rd_ff <= rd_mstat;
      sleep_en_ff <= ien_eff[uie_pkg::IEN_SLEEP];
      irq_ff <= pend_any;
    end
  end

endmodule // uie_top

// >>> pkg/uie_pkg.sv
// uie_pkg: constants and carrier types for the per-channel register and
// interrupt block; assumes one channel, an 8-bit register port and A2-A0.
package uie_pkg;

  // register offsets, normal map
  localparam logic [2:0] OFS_HOLD = 3'h0;
  localparam logic [2:0] OFS_IEN = 3'h1;
  localparam logic [2:0] OFS_ISTAT = 3'h2;
  localparam logic [2:0] OFS_LCTRL = 3'h3;
  localparam logic [2:0] OFS_MCTRL = 3'h4;
  localparam logic [2:0] OFS_LSTAT = 3'h5;
  localparam logic [2:0] OFS_MSTAT = 3'h6;
  localparam logic [2:0] OFS_SCRATCH = 3'h7;
  // register offsets, enhanced map
  localparam logic [2:0] OFS_EFC = 3'h2;
  localparam logic [2:0] OFS_RES1 = 3'h4;
  localparam logic [2:0] OFS_RES2 = 3'h5;
  localparam logic [2:0] OFS_STOP1 = 3'h6;
  localparam logic [2:0] OFS_STOP2 = 3'h7;

  // line control key that opens the enhanced map
  localparam logic [7:0] LCTRL_KEY = 8'hBF;
  localparam int LCTRL_DIV_BIT = 7;

  // enhanced feature control fields
  localparam int EFC_AUTO_CTS = 7;
  localparam int EFC_AUTO_RTS = 6;
  localparam int EFC_ENH = 4;

  // interrupt enable fields
  localparam int IEN_RX = 0;
  localparam int IEN_TX = 1;
  localparam int IEN_LINE = 2;
  localparam int IEN_MODEM = 3;
  localparam int IEN_SLEEP = 4;
  localparam int IEN_STOPCH = 5;
  localparam int IEN_RTS = 6;
  localparam int IEN_CTS = 7;

  // fifo control fields
  localparam int FCTL_EN = 0;
  localparam int FCTL_RXRST = 1;
  localparam int FCTL_TXRST = 2;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;

  // interrupt status codes, low six bits
  localparam logic [5:0] ISC_LINE = 6'h06;
  localparam logic [5:0] ISC_RXTO = 6'h0C;
  localparam logic [5:0] ISC_RXRDY = 6'h04;
  localparam logic [5:0] ISC_TXRDY = 6'h02;
  localparam logic [5:0] ISC_MODEM = 6'h00;
  localparam logic [5:0] ISC_STOPCH = 6'h10;
  localparam logic [5:0] ISC_FLOW = 6'h20;
  localparam logic [5:0] ISC_NONE = 6'h01;

  // trigger tables, indexed by the two select bits
  localparam logic [3:0][5:0] RX_TRIG_TBL = {6'h1E, 6'h18, 6'h10, 6'h08};
  localparam logic [3:0][5:0] TX_TRIG_TBL = {6'h1E, 6'h18, 6'h08, 6'h10};

  typedef struct packed {
    logic cs;
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } uie_bus_s;

  typedef struct packed {
    logic [5:0] count;
    logic overrun;
    logic brk;
    logic framing;
    logic parity;
    logic any_err;
    logic timeout;
  } uie_rx_s;

  typedef struct packed {
    logic [5:0] count;
    logic shift_empty;
  } uie_tx_s;

endpackage

// >>> src/uie_rise_det.sv
// uie_rise_det: low-to-high detector per bit, one-cycle pulse out.
// assumes inputs already synchronous to clk_sys.
`timescale 1ns/1ps
module uie_rise_det #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // levels in, pulses out
  input wire logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic prev_ff;
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          prev_ff <= 1'b1;
        end else begin
          prev_ff <= level[i];
        end
      end
      assign rise[i] = level[i] & ~prev_ff;
    end
  endgenerate
endmodule // uie_rise_det

// >>> bench/uie_top_assertions.sv
// uie_top_assertions: port-level checks of the register and irq block.
// assumes uie_pkg compiled first; bound into every uie_top.
`timescale 1ns/1ps
module uie_chk (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // watched ports
  input wire uie_pkg::uie_bus_s bus,
  input wire logic [7:0] rdata_ff,
  input wire uie_pkg::uie_rx_s rx_stat,
  input wire uie_pkg::uie_tx_s tx_stat,
  input wire logic rx_hold_rd_ff,
  input wire logic tx_hold_wr_ff,
  input wire logic [7:0] tx_hold_data_ff,
  input wire logic [7:0] line_control_reg_ff,
  input wire logic [7:0] enhanced_feature_ctrl_ff,
  input wire logic [7:0] resume_char_one_ff,
  input wire logic [7:0] modem_control_reg_ff,
  input wire logic rx_fifo_rst_ff,
  input wire logic tx_fifo_rst_ff,
  input wire logic fifo_en_ff,
  input wire logic sleep_en_ff,
  input wire logic irq_ff
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire logic nrm = !line_control_reg_ff[7];
  wire logic key = line_control_reg_ff == uie_pkg::LCTRL_KEY;
  wire logic rd_n = bus.cs && bus.rd;
  wire logic wr_n = bus.cs && bus.wr;
  wire logic lsr_rd = rd_n && nrm && bus.addr == uie_pkg::OFS_LSTAT;
  a_reset_clear: assert property (disable iff (1'b0) sys_rst |=>
    !irq_ff && rdata_ff == 8'h00 && !sleep_en_ff) else $error("reset state wrong");
  a_rdata_hold: assert property (!rd_n |=> $stable(rdata_ff))
    else $error("read data moved without read");
  a_efc_write: assert property (wr_n && key && bus.addr == uie_pkg::OFS_EFC |=>
    enhanced_feature_ctrl_ff == $past(bus.wdata)) else $error("feature ctrl not written");
  a_char_write: assert property (wr_n && key && bus.addr == uie_pkg::OFS_RES1 |=>
    resume_char_one_ff == $past(bus.wdata)) else $error("resume char not written");
  a_sleep_gate: assert property (sleep_en_ff |->
    $past(enhanced_feature_ctrl_ff[uie_pkg::EFC_ENH])) else $error("sleep without access");
  a_hold_read: assert property (rd_n && nrm && bus.addr == uie_pkg::OFS_HOLD |=>
    rx_hold_rd_ff) else $error("hold read strobe missing");
  a_hold_write: assert property (wr_n && nrm && bus.addr == uie_pkg::OFS_HOLD |=>
    tx_hold_wr_ff && tx_hold_data_ff == $past(bus.wdata)) else $error("hold write wrong");
  a_fifo_mode: assert property (wr_n && nrm && bus.addr == uie_pkg::OFS_ISTAT |=>
    fifo_en_ff == $past(bus.wdata[0])) else $error("fifo mode not taken");
  a_lstat_bits: assert property (lsr_rd |=> rdata_ff[7:2] == $past({rx_stat.any_err,
    tx_stat.count == 6'h00 && tx_stat.shift_empty, tx_stat.count == 6'h00, rx_stat.brk,
    rx_stat.framing, rx_stat.parity})) else $error("line status bits wrong");
  a_data_ready: assert property (lsr_rd |=> rdata_ff[0] ==
    ($past(rx_stat.count) != 6'h00)) else $error("data ready wrong");
  a_fifo_reset: assert property (wr_n && nrm && bus.addr == uie_pkg::OFS_ISTAT &&
    bus.wdata[uie_pkg::FCTL_EN] |=>
    rx_fifo_rst_ff == $past(bus.wdata[uie_pkg::FCTL_RXRST]) &&
    tx_fifo_rst_ff == $past(bus.wdata[uie_pkg::FCTL_TXRST]))
    else $error("fifo reset pulse wrong");
  a_mctrl_gate: assert property (wr_n && nrm && bus.addr == uie_pkg::OFS_MCTRL &&
    !enhanced_feature_ctrl_ff[uie_pkg::EFC_ENH] |=>
    modem_control_reg_ff[7:5] == $past(modem_control_reg_ff[7:5]))
    else $error("modem ctrl high bits written without access");
endmodule // uie_chk
bind uie_top uie_chk uie_chk_i (.clk_sys, .sys_rst, .bus, .rdata_ff, .rx_stat, .tx_stat,
  .rx_hold_rd_ff, .tx_hold_wr_ff, .tx_hold_data_ff, .line_control_reg_ff,
  .enhanced_feature_ctrl_ff, .resume_char_one_ff, .modem_control_reg_ff, .rx_fifo_rst_ff,
  .tx_fifo_rst_ff, .fifo_en_ff, .sleep_en_ff, .irq_ff);

// >>> bench/uie_dp_model.sv
// uie_dp_model: small receive/transmit/modem datapath facing the block.
// assumes strobes from uie_top; the bench pushes chars and sets flags.
`timescale 1ns/1ps
module uie_dp_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // strobes from the channel
  input wire logic rx_hold_rd_ff,
  input wire logic tx_hold_wr_ff,
  input wire logic modem_stat_rd_ff,
  // bench controls
  input wire logic push,
  input wire logic [4:0] flags,
  input wire logic delta_set,
  // status to the channel
  output uie_pkg::uie_rx_s rx_stat,
  output uie_pkg::uie_tx_s tx_stat,
  output logic [7:0] rx_hold_data,
  output logic modem_delta
);
  logic [5:0] rx_cnt_ff;
  logic [5:0] tx_cnt_ff;
  logic delta_ff;
  assign rx_stat = {rx_cnt_ff, flags, 1'b0};
  assign tx_stat = {tx_cnt_ff, tx_cnt_ff == 6'h00};
  // head byte mirrors the level so reads are checkable
  assign rx_hold_data = {2'h0, rx_cnt_ff};
  assign modem_delta = delta_ff;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rx_cnt_ff <= 6'h00;
      tx_cnt_ff <= 6'h00;
      delta_ff <= 1'b0;
    end else begin
      rx_cnt_ff <= rx_cnt_ff + {5'h00, push} - {5'h00, rx_hold_rd_ff && rx_cnt_ff != 6'h00};
      tx_cnt_ff <= tx_cnt_ff + {5'h00, tx_hold_wr_ff} - {5'h00, tx_cnt_ff != 6'h00};
      delta_ff <= delta_set || (delta_ff && !modem_stat_rd_ff);
    end
  end
endmodule // uie_dp_model

// >>> bench/test_uie_top.sv
// test_uie_top: register-level sequences against uie_top and the model.
// assumes uie_pkg, uie_top, uie_dp_model and the bound checker.
`timescale 1ns/1ps
module test_uie_top;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  uie_pkg::uie_bus_s bus = '0;
  logic push = 1'b0;
  logic [4:0] flags = 5'h00;
  logic delta_set = 1'b0;
  logic rts = 1'b0;
  logic stop = 1'b0;
  logic cts = 1'b0;
  logic [7:0] mstat = 8'h5A;
  logic [7:0] rdata_ff;
  logic rx_rd, tx_wr, ms_rd, sleep_en_ff, irq_ff, mdelta;
  logic [7:0] hold;
  uie_pkg::uie_rx_s rx_stat;
  uie_pkg::uie_tx_s tx_stat;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  int i;
  always #2.5 clk_sys = ~clk_sys;
  uie_top uie_top_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(bus), .rdata_ff(rdata_ff),
    .rx_stat(rx_stat), .tx_stat(tx_stat), .rx_hold_data(hold), .modem_stat(mstat),
    .modem_delta(mdelta), .stop_char_seen(stop), .resume_char_seen(1'b0),
    .rts_out_high(rts), .cts_in_high(cts), .rx_hold_rd_ff(rx_rd), .tx_hold_wr_ff(tx_wr),
    .tx_hold_data_ff(), .modem_stat_rd_ff(ms_rd), .rx_fifo_rst_ff(), .tx_fifo_rst_ff(),
    .line_control_reg_ff(), .enhanced_feature_ctrl_ff(), .resume_char_one_ff(),
    .resume_char_two_ff(), .stop_char_one_ff(), .stop_char_two_ff(),
    .modem_control_reg_ff(), .fifo_en_ff(), .sleep_en_ff(sleep_en_ff), .irq_ff(irq_ff));
  uie_dp_model uie_dp_model_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .rx_hold_rd_ff(rx_rd),
    .tx_hold_wr_ff(tx_wr), .modem_stat_rd_ff(ms_rd), .push(push), .flags(flags),
    .delta_set(delta_set), .rx_stat(rx_stat), .tx_stat(tx_stat), .rx_hold_data(hold),
    .modem_delta(mdelta));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{1'b1, 1'b0, 1'b1, a, d};
    @(posedge clk_sys);
    bus <= '0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    bus <= '{1'b1, 1'b1, 1'b0, a, 8'h00};
    @(posedge clk_sys);
    bus <= '0;
    #1 chk(rdata_ff, e);
  endtask
  task automatic irq(input logic e);
    repeat (5) @(posedge clk_sys);
    #1 chk({7'h00, irq_ff}, {7'h00, e});
  endtask
  task automatic report_and_stop();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(1, 8'h00);
    rd(2, 8'h01);
    irq(0);
    wr(1, 8'h02);
    irq(1);
    rd(2, 8'h02);
    irq(0);
    wr(0, 8'h33);
    irq(1);
    wr(1, 8'hF2);
    rd(1, 8'h02);
    wr(4, 8'hFF);
    rd(4, 8'h1F);
    wr(1, 8'h00);
    wr(3, 8'hBF);
    wr(2, 8'h10);
    for (i = 4; i < 8; i++) wr(i[2:0], 8'(8'h11 * i));
    for (i = 4; i < 8; i++) rd(i[2:0], 8'(8'h11 * i));
    rd(2, 8'h10);
    rd(0, 8'h00);
    wr(3, 8'h03);
    wr(1, 8'h10);
    rd(1, 8'h10);
    chk({7'h00, sleep_en_ff}, 8'h01);
    wr(2, 8'h07);
    wr(1, 8'h01);
    @(posedge clk_sys) push <= 1'b1;
    repeat (8) @(posedge clk_sys);
    push <= 1'b0;
    irq(1);
    rd(2, 8'hC4);
    rd(5, 8'h61);
    rd(0, 8'h08);
    irq(0);
    for (i = 7; i > 0; i--) rd(0, 8'(i));
    rd(5, 8'h60);
    wr(1, 8'h04);
    @(posedge clk_sys) flags <= 5'h18;
    @(posedge clk_sys) flags <= 5'h08;
    irq(1);
    rd(5, 8'h72);
    @(posedge clk_sys) flags <= 5'h01;
    rd(5, 8'hE0);
    irq(0);
    @(posedge clk_sys) flags <= 5'h00;
    wr(1, 8'h08);
    @(posedge clk_sys) delta_set <= 1'b1;
    @(posedge clk_sys) delta_set <= 1'b0;
    irq(1);
    rd(6, 8'h5A);
    irq(0);
    wr(3, 8'hBF);
    wr(2, 8'h50);
    wr(3, 8'h03);
    wr(1, 8'h40);
    @(posedge clk_sys) rts <= 1'b1;
    irq(1);
    rd(2, 8'hE0);
    rd(6, 8'h5A);
    irq(0);
    wr(3, 8'hBF);
    wr(2, 8'h90);
    rd(3, 8'hBF);
    wr(3, 8'h03);
    wr(4, 8'hA5);
    rd(4, 8'hA5);
    wr(7, 8'h3C);
    rd(7, 8'h3C);
    wr(1, 8'hA0);
    @(posedge clk_sys) stop <= 1'b1;
    @(posedge clk_sys) stop <= 1'b0;
    irq(1);
    rd(2, 8'hD0);
    irq(0);
    @(posedge clk_sys) cts <= 1'b1;
    irq(1);
    rd(2, 8'hE0);
    rd(6, 8'h5A);
    irq(0);
    report_and_stop();
  end
endmodule // test_uie_top
